// *** ddt_pkg.sv ***
// How it works
// RULE1 - fifteen stage prescaler from 32 kHz crystal
// RULE2 - timer one: 8-bit down, three modes
// RULE3 - timer one clock: 4k, 2k, 1k, 512 Hz
// RULE4 - zero-stop: nonzero load starts, zero halts, interrupts
// RULE5 - synchronized: start waits for 64 Hz edge
// RULE6 - synchronized count gates high-drive outputs, else high
// RULE7 - software picks nine down to three gated outputs
// RULE8 - timer two: 8-bit down, zero-stop or reload
// RULE9 - reload: keep load, reload at zero, repeat
// RULE10 - reload: interrupt at every zero
// RULE11 - timer two clock: 256, 64, 16, 4 Hz
// RULE12 - load while counting replaces count and reload
package ddt_pkg;

	localparam int PRE_STAGES = 15;

	localparam logic [7:0] A_T1_CTRL   = 8'h00;
	localparam logic [7:0] A_T1_LOAD   = 8'h04;
	localparam logic [7:0] A_T2_CTRL   = 8'h08;
	localparam logic [7:0] A_T2_LOAD   = 8'h0c;
	localparam logic [7:0] A_PORT      = 8'h10;
	localparam logic [7:0] A_IRQ_STAT  = 8'h14;
	localparam logic [7:0] A_IRQ_MASK  = 8'h18;
	localparam logic [7:0] A_PRESCALER = 8'h1c;

	localparam int T1_MODE_LSB = 0;
	localparam int T1_CLK_LSB  = 2;
	localparam int T1_GATE_LSB = 4;
	localparam int T2_MODE_BIT = 0;
	localparam int T2_CLK_LSB  = 1;
	localparam int IRQ_T1      = 0;
	localparam int IRQ_T2      = 1;

	localparam logic [1:0] MODE_ZERO_STOP = 2'h0;
	localparam logic [1:0] MODE_SYNC      = 2'h1;
	localparam logic [1:0] MODE_RELOAD    = 2'h2;

	// prescaler bit k runs at 32768 / 2^(k+1) Hz
	localparam logic [3:0][3:0] T1_TAP   = {4'h5, 4'h4, 4'h3, 4'h2};
	localparam logic [3:0][3:0] T2_TAP   = {4'hc, 4'ha, 4'h8, 4'h6};
	localparam logic [3:0]      SYNC_TAP = 4'h8;

	localparam int         HD_PINS  = 9;
	localparam logic [2:0] GATE_MAX = 3'h6;
	localparam logic [8:0] PORT_RST = 9'h000;
	localparam logic [8:0] HD_RST   = 9'h1ff;

	typedef struct packed {
		logic       high_drive_extra_pin;
		logic [3:0] high_drive_port_b;
		logic [3:0] high_drive_port_a;
	} ddt_hd_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] rld;
		logic       run;
		logic       arm;
	} ddt_tmr_t;

	typedef struct packed {
		logic [2:0] gate;
		logic [1:0] clk;
		logic [1:0] mode;
	} ddt_t1_cfg_t;

	typedef struct packed {
		logic [1:0] clk;
		logic       mode;
	} ddt_t2_cfg_t;

	typedef struct packed {
		logic       act;
		logic       wr;
		logic [7:0] addr;
	} ddt_bus_t;

	typedef struct packed {
		logic                  xs1;
		logic                  xs2;
		logic                  xprev;
		logic [PRE_STAGES-1:0] pre;
		ddt_t1_cfg_t           c1;
		ddt_t2_cfg_t           c2;
		ddt_tmr_t              t1;
		ddt_tmr_t              t2;
		logic [8:0]            port;
		logic [1:0]            ist;
		logic [1:0]            imsk;
		ddt_bus_t              bus;
		logic [31:0]           rdata;
		ddt_hd_t               hd;
	} ddt_state_t;

endpackage

// *** ddt_timers.sv ***
`timescale 1ns/1ps
module ddt_timers (
	input  logic             hclk,
	input  logic             hresetn,
	input  logic             hsel,
	input  logic [31:0]      haddr,
	input  logic [1:0]       htrans,
	input  logic             hwrite,
	input  logic [2:0]       hsize,
	input  logic [31:0]      hwdata,
	input  logic             hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  logic             xtal_clk,
	output logic             irq,
	output ddt_pkg::ddt_hd_t hd_out
);

	localparam ddt_pkg::ddt_state_t ST_RST = '{
		port:    ddt_pkg::PORT_RST,
		hd:      ddt_pkg::HD_RST,
		default: '0
	};

	ddt_pkg::ddt_state_t st_q;
	ddt_pkg::ddt_state_t st_d;

	logic       xe;
	logic       tk1;
	logic       tk2;
	logic       tk64;
	logic       wr;
	logic       ld1;
	logic       ld2;
	logic       z1;
	logic       z2;
	logic       sact;
	logic [8:0] gm;

	// high when the selected prescaler bit goes from 0 to 1 on the next increment
	function automatic logic tap_rise(
		input logic [ddt_pkg::PRE_STAGES-1:0] p,
		input logic [3:0]                     k
	);
		logic r;
		r = ~p[k];
		for (int i = 0; i < ddt_pkg::PRE_STAGES; i++) begin
			if (i < int'(k)) begin
				r = r & p[i];
			end
		end
		return r;
	endfunction

	// the lowest n outputs take part in the gating, n from nine down to three
	function automatic logic [8:0] gate_mask(input logic [2:0] sel);
		logic [8:0] m;
		int         n;
		n = (sel > ddt_pkg::GATE_MAX) ? 3 : ddt_pkg::HD_PINS - int'(sel);
		for (int i = 0; i < ddt_pkg::HD_PINS; i++) begin
			m[i] = (i < n);
		end
		return m;
	endfunction

	// one count step; a reloading timer holds zero for one tick, then reloads
	function automatic ddt_pkg::ddt_tmr_t tmr_step(
		input ddt_pkg::ddt_tmr_t t,
		input logic              tk,
		input logic              rl
	);
		ddt_pkg::ddt_tmr_t r;
		r = t;
		if (tk && t.run) begin
			if (t.cnt == 8'h00) begin
				if (rl) begin
					r.cnt = t.rld; // [RULE9]
				end else begin
					r.run = 1'b0;
				end
			end else begin
				r.cnt = t.cnt - 8'h01;
				if (t.cnt == 8'h01 && !rl) begin
					r.run = 1'b0; // [RULE4]
				end
			end
		end
		return r;
	endfunction

	// a zero load stops the timer; a sync-mode timer that is idle is armed to wait for the 64 Hz edge
	function automatic ddt_pkg::ddt_tmr_t tmr_load(
		input ddt_pkg::ddt_tmr_t t,
		input logic [7:0]        v,
		input logic              sy
	);
		ddt_pkg::ddt_tmr_t r;
		r = t;
		r.cnt = v; // [RULE12]
		r.rld = v; // [RULE9]
		if (v == 8'h00) begin
			r.run = 1'b0;
			r.arm = 1'b0;
		end else if (sy && !t.run) begin
			r.arm = 1'b1; // [RULE5]
		end else begin
			r.run = 1'b1; // [RULE4]
			r.arm = 1'b0;
		end
		return r;
	endfunction

	assign xe   = st_q.xs2 & ~st_q.xprev;
	assign tk1  = xe & tap_rise(st_q.pre, ddt_pkg::T1_TAP[st_q.c1.clk]); // [RULE3]
	assign tk2  = xe & tap_rise(st_q.pre, ddt_pkg::T2_TAP[st_q.c2.clk]); // [RULE11]
	assign tk64 = xe & tap_rise(st_q.pre, ddt_pkg::SYNC_TAP);            // [RULE5]
	assign wr   = st_q.bus.act & st_q.bus.wr;
	assign ld1  = wr & (st_q.bus.addr == ddt_pkg::A_T1_LOAD);
	assign ld2  = wr & (st_q.bus.addr == ddt_pkg::A_T2_LOAD);
	assign z1   = tk1 & st_q.t1.run & (st_q.t1.cnt == 8'h01) & ~ld1; // [RULE4]
	assign z2   = tk2 & st_q.t2.run & (st_q.t2.cnt == 8'h01) & ~ld2; // [RULE10]
	assign sact = (st_q.c1.mode == ddt_pkg::MODE_SYNC) & st_q.t1.run;
	assign gm   = gate_mask(st_q.c1.gate); // [RULE7]

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st_q.rdata;
	assign irq       = |(st_q.ist & st_q.imsk);
	assign hd_out    = st_q.hd;

	always_comb begin
		logic [1:0] clr;
		clr = 2'h0;
		st_d = st_q;

		// crystal pin crosses in through two flops before the edge detector
		st_d.xs1   = xtal_clk;
		st_d.xs2   = st_q.xs1;
		st_d.xprev = st_q.xs2;
		if (xe) begin
			st_d.pre = st_q.pre + 15'h0001; // [RULE1]
		end

		st_d.t1 = tmr_step(st_q.t1, tk1, st_q.c1.mode == ddt_pkg::MODE_RELOAD); // [RULE2]
		if (st_q.t1.arm && tk64) begin
			st_d.t1.run = 1'b1; // [RULE5]
			st_d.t1.arm = 1'b0;
		end
		st_d.t2 = tmr_step(st_q.t2, tk2, st_q.c2.mode); // [RULE8]

		// address phase: only whole-word writes are taken; reads of any size load rdata
		st_d.bus.act  = hsel & htrans[1] & hready & (hsize == 3'h2);
		st_d.bus.wr   = hwrite;
		st_d.bus.addr = haddr[7:0];
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				ddt_pkg::A_T1_CTRL: begin
					st_d.rdata = {22'h0, st_q.t1.arm, st_q.t1.run, 1'b0, st_q.c1};
				end
				ddt_pkg::A_T1_LOAD: begin
					st_d.rdata = {24'h0, st_q.t1.cnt};
				end
				ddt_pkg::A_T2_CTRL: begin
					st_d.rdata = {23'h0, st_q.t2.run, 5'h0, st_q.c2};
				end
				ddt_pkg::A_T2_LOAD: begin
					st_d.rdata = {24'h0, st_q.t2.cnt};
				end
				ddt_pkg::A_PORT: begin
					st_d.rdata = {23'h0, st_q.port};
				end
				ddt_pkg::A_IRQ_STAT: begin
					st_d.rdata = {30'h0, st_q.ist};
				end
				ddt_pkg::A_IRQ_MASK: begin
					st_d.rdata = {30'h0, st_q.imsk};
				end
				ddt_pkg::A_PRESCALER: begin
					st_d.rdata = {17'h0, st_q.pre};
				end
				default: begin
					st_d.rdata = 32'h0;
				end
			endcase
		end

		// data phase: a load overrides a count step in the same cycle
		if (wr) begin
			case (st_q.bus.addr)
				ddt_pkg::A_T1_CTRL: begin
					st_d.c1.mode = hwdata[ddt_pkg::T1_MODE_LSB +: 2]; // [RULE2]
					st_d.c1.clk  = hwdata[ddt_pkg::T1_CLK_LSB +: 2];  // [RULE3]
					st_d.c1.gate = hwdata[ddt_pkg::T1_GATE_LSB +: 3]; // [RULE7]
				end
				ddt_pkg::A_T1_LOAD: begin
					st_d.t1 = tmr_load(st_q.t1, hwdata[7:0],
						st_q.c1.mode == ddt_pkg::MODE_SYNC); // [RULE12]
				end
				ddt_pkg::A_T2_CTRL: begin
					st_d.c2.mode = hwdata[ddt_pkg::T2_MODE_BIT];     // [RULE8]
					st_d.c2.clk  = hwdata[ddt_pkg::T2_CLK_LSB +: 2]; // [RULE11]
				end
				ddt_pkg::A_T2_LOAD: begin
					st_d.t2 = tmr_load(st_q.t2, hwdata[7:0], 1'b0); // [RULE12]
				end
				ddt_pkg::A_PORT: begin
					st_d.port = hwdata[8:0];
				end
				ddt_pkg::A_IRQ_STAT: begin
					clr = hwdata[1:0];
				end
				ddt_pkg::A_IRQ_MASK: begin
					st_d.imsk = hwdata[1:0];
				end
				default: begin
					st_d.port = st_q.port;
				end
			endcase
		end

		// a new zero event wins over a clear in the same cycle
		st_d.ist = (st_q.ist & ~clr) | {z2, z1}; // [RULE10]

		// gated pins sit high unless timer one counts in synchronized mode
		st_d.hd = st_q.port | (gm & {9{~sact}}); // [RULE6]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_pre_advance: assert property (xe |=> st_q.pre == $past(st_q.pre) + 15'h0001) // [RULE1]
		else $error("prescaler did not advance on crystal edge");

	a_t1_decrement: assert property (
		tk1 && st_q.t1.run && st_q.t1.cnt > 8'h01 && !ld1
		|=> st_q.t1.cnt == $past(st_q.t1.cnt) - 8'h01) // [RULE2]
		else $error("timer one did not count down");

	a_t1_tap: assert property (
		!ld1 && st_q.t1.run && st_q.t1.cnt > 8'h01 && !tk1
		|=> st_q.t1.cnt == $past(st_q.t1.cnt)) // [RULE3]
		else $error("timer one moved without its tap");

	a_zs_halt: assert property (
		z1 && st_q.c1.mode == ddt_pkg::MODE_ZERO_STOP
		|=> !st_q.t1.run && st_q.t1.cnt == 8'h00 && st_q.ist[ddt_pkg::IRQ_T1]) // [RULE4]
		else $error("zero-stop timer did not halt with request");

	a_sync_wait: assert property (
		st_q.t1.arm && !tk64 && !ld1 |=> !st_q.t1.run && st_q.t1.arm) // [RULE5]
		else $error("synchronized start before 64 Hz edge");

	a_sync_start: assert property (
		st_q.t1.arm && tk64 && !ld1 |=> st_q.t1.run && !st_q.t1.arm) // [RULE5]
		else $error("synchronized start missed 64 Hz edge");

	a_gate_drive: assert property (
		sact && gm[0] |=> st_q.hd.high_drive_port_a[0] == $past(st_q.port[0])) // [RULE6]
		else $error("gated pin not driving data while counting");

	a_gate_idle: assert property (
		!sact && gm[0] |=> st_q.hd.high_drive_port_a[0]) // [RULE6]
		else $error("gated pin not high while idle");

	a_gate_count: assert property (
		st_q.c1.gate == 3'h6 && !sact
		|=> st_q.hd.high_drive_extra_pin == $past(st_q.port[8])) // [RULE7]
		else $error("ungated pin followed the gating");

	a_t2_halt: assert property (
		z2 && !st_q.c2.mode |=> !st_q.t2.run) // [RULE8]
		else $error("timer two zero-stop did not halt");

	a_t2_reload: assert property (
		tk2 && st_q.t2.run && st_q.t2.cnt == 8'h00 && st_q.c2.mode && !ld2
		|=> st_q.t2.cnt == $past(st_q.t2.rld) && st_q.t2.run) // [RULE9]
		else $error("timer two did not reload");

	a_t2_request: assert property (z2 |=> st_q.ist[ddt_pkg::IRQ_T2] ##1 st_q.t2.run
		|| !st_q.c2.mode) // [RULE10]
		else $error("timer two zero gave no request");

	a_t2_tap: assert property (
		!ld2 && st_q.t2.run && st_q.t2.cnt > 8'h01 && !tk2
		|=> st_q.t2.cnt == $past(st_q.t2.cnt)) // [RULE11]
		else $error("timer two moved without its tap");

	a_load_replace: assert property (
		ld1 && hwdata[7:0] != 8'h00
		|=> st_q.t1.cnt == $past(hwdata[7:0]) && st_q.t1.rld == $past(hwdata[7:0])) // [RULE12]
		else $error("load did not replace count and reload");

	// a halted timer must not drift, or a later zero-stop would fire early
	a_t1_halt_hold: assert property (
		!st_q.t1.run && !st_q.t1.arm && !ld1
		|=> st_q.t1.cnt == $past(st_q.t1.cnt)) // [RULE4]
		else $error("halted timer one count moved");

	a_zero_load: assert property (
		ld1 && hwdata[7:0] == 8'h00 |=> !st_q.t1.run && !st_q.t1.arm) // [RULE4]
		else $error("zero load left timer one running");

	a_sync_arm: assert property (
		ld1 && hwdata[7:0] != 8'h00 && st_q.c1.mode == ddt_pkg::MODE_SYNC && !st_q.t1.run
		|=> st_q.t1.arm && !st_q.t1.run) // [RULE5]
		else $error("synchronized load started without 64 Hz edge");

	a_t1_reload: assert property (
		tk1 && st_q.t1.run && st_q.t1.cnt == 8'h00 && !ld1
		&& st_q.c1.mode == ddt_pkg::MODE_RELOAD
		|=> st_q.t1.cnt == $past(st_q.t1.rld) && st_q.t1.run) // [RULE9]
		else $error("timer one did not reload");

	a_t1_request: assert property (z1 |=> st_q.ist[ddt_pkg::IRQ_T1]) // [RULE10]
		else $error("timer one zero gave no request");

	a_t2_decrement: assert property (
		tk2 && st_q.t2.run && st_q.t2.cnt > 8'h01 && !ld2
		|=> st_q.t2.cnt == $past(st_q.t2.cnt) - 8'h01) // [RULE8]
		else $error("timer two did not count down");

	a_load_start: assert property (
		ld2 && hwdata[7:0] != 8'h00
		|=> st_q.t2.run && st_q.t2.cnt == $past(hwdata[7:0])) // [RULE9]
		else $error("timer two did not start on load");

	a_set_wins: assert property (
		z2 && wr && st_q.bus.addr == ddt_pkg::A_IRQ_STAT && hwdata[ddt_pkg::IRQ_T2]
		|=> st_q.ist[ddt_pkg::IRQ_T2]) // [RULE10]
		else $error("clear beat a new timer two request");

	c_zero_stop: cover property (z1 && st_q.c1.mode == ddt_pkg::MODE_ZERO_STOP);
	c_sync_run: cover property (st_q.t1.arm && tk64);
	c_reload: cover property (
		z1 && st_q.c1.mode == ddt_pkg::MODE_RELOAD ##[1:300] tk1 && st_q.t1.cnt == 8'h00);
	c_irq: cover property ($rose(irq));
	c_load_busy: cover property (ld1 && st_q.t1.run);

endmodule

// *** ddt_cpu.sv ***
`timescale 1ns/1ps
module ddt_cpu (
	input  logic        hclk,
	input  logic        hreadyout,
	input  logic [31:0] hrdata,
	output logic        hsel,
	output logic [31:0] haddr,
	output logic [1:0]  htrans,
	output logic        hwrite,
	output logic [2:0]  hsize,
	output logic [31:0] hwdata,
	output logic        hang
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hang = 1'b0;
	end
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(posedge hclk);
			n++;
		end
		if (n == 64)
			hang <= 1'b1;
	endtask
	// entry waits an edge, so one idle cycle always parts two transfers
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
	logic             hclk, hresetn, xtal_clk, hsel, hwrite, hreadyout, hresp, irq, hang;
	logic [31:0]      haddr, hwdata, hrdata, q, seed, p1;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic [8:0]       port;
	ddt_pkg::ddt_hd_t hd_out;
	int               fail_count, n_tests, c;
	initial hclk = 1'b0;
	always #12.5 hclk = ~hclk;
	// crystal sped up to 4 hclk a cycle; every tick period below is in hclk
	always #50 xtal_clk = ~xtal_clk;
	ddt_timers u_ddt_timers (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.xtal_clk(xtal_clk), .irq(irq), .hd_out(hd_out));
	ddt_cpu u_ddt_cpu (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hang(hang));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [8:0] exp_hd(input logic [8:0] p, input int g);
		int n;
		n = (g > 6) ? 3 : 9 - g;
		return p | ((9'h1 << n) - 9'h1);
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge hclk) if (hang === 1'b1) begin
		fail_count++;
		stop_test();
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_ddt_cpu.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		u_ddt_cpu.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic wait_irq();
		c = 0;
		// skip the edge of a just-written clear, whose update is not yet visible
		@(posedge hclk);
		while (irq !== 1'b1 && c < 70000) begin
			@(posedge hclk);
			c++;
		end
		if (c == 70000) begin
			fail_count++;
			stop_test();
		end
	endtask
	task automatic zero_run(input logic [7:0] ca, la, input logic [31:0] cv, input int p, n,
			input logic [31:0] ib);
		wr(ca, cv);
		wr(la, n);
		wait_irq();
		chk(c >= (n - 1) * p - 4 && c <= n * p + 16, 1);
		repeat (64) @(posedge hclk);
		rd(la);
		chk(q, 0);
		rd(ca);
		chk(q[8], 0);
		rd(ddt_pkg::A_IRQ_STAT);
		chk(q, ib);
		wr(ddt_pkg::A_IRQ_STAT, ib);
		#1 chk(irq, 0);
	endtask
	task automatic reload_run(input logic [7:0] ca, la, input logic [31:0] cv, input int p,
			input logic [31:0] ib);
		wr(ca, cv);
		wr(la, 2);
		wait_irq();
		wr(ddt_pkg::A_IRQ_STAT, ib);
		wait_irq();
		chk(c >= 3 * p - 16 && c <= 3 * p + 16, 1);
		rd(ca);
		chk(q[8], 1);
		wr(la, 5);
		rd(la);
		chk(q == 5 || q == 4, 1);
		wr(ddt_pkg::A_IRQ_STAT, ib);
		wait_irq();
		chk(c >= 4 * p - 16 && c <= 5 * p + 16, 1);
		wr(la, 0);
		wr(ddt_pkg::A_IRQ_STAT, ib);
	endtask
	initial begin
		hresetn = 1'b0;
		xtal_clk = 1'b0;
		seed = 32'h9bd6;
		fail_count = 0;
		n_tests = 0;
		repeat (2) @(posedge hclk);
		chk(hd_out, 9'h1ff);
		chk(irq, 0);
		chk(hresp, 0);
		hresetn <= 1'b1;
		for (int i = 0; i < 9; i++) if (i != 7) begin
			rd(8'(i * 4));
			chk(q, 0);
		end
		rd(ddt_pkg::A_PRESCALER);
		p1 = q;
		repeat (40) @(posedge hclk);
		rd(ddt_pkg::A_PRESCALER);
		chk(q[31:15], 0);
		chk(q - p1 >= 9 && q - p1 <= 12, 1);
		wr(8'h20, rnd());
		rd(8'h20);
		chk(q, 0);
		wr(ddt_pkg::A_IRQ_MASK, 3);
		q = rnd();
		port = q[8:0];
		wr(ddt_pkg::A_PORT, {23'h0, port});
		for (int g = 0; g < 8; g++) begin
			wr(ddt_pkg::A_T1_CTRL, g << 4);
			repeat (2) @(posedge hclk);
			chk(hd_out, exp_hd(port, g));
		end
		for (int s = 0; s < 4; s++)
			zero_run(ddt_pkg::A_T1_CTRL, ddt_pkg::A_T1_LOAD, s << 2, 32 << s, 2, 1);
		for (int s = 0; s < 4; s++)
			zero_run(ddt_pkg::A_T2_CTRL, ddt_pkg::A_T2_LOAD, s << 1, 512 << (2 * s),
				(s == 3) ? 1 : 2, 2);
		q = rnd();
		port = q[8:0] & 9'h1fe;
		wr(ddt_pkg::A_PORT, {23'h0, port});
		wr(ddt_pkg::A_T1_CTRL, 1);
		wr(ddt_pkg::A_T1_LOAD, 3);
		rd(ddt_pkg::A_T1_CTRL);
		chk(q[9:8], 2'h2);
		chk(hd_out, exp_hd(port, 0));
		c = 0;
		while (hd_out !== port && c < 2100) begin
			@(posedge hclk);
			c++;
		end
		chk(c < 2100, 1);
		rd(ddt_pkg::A_PRESCALER);
		chk(q[8:0] >= 9'h100 && q[8:0] < 9'h104, 1);
		wait_irq();
		chk(c >= 56 && c <= 112, 1);
		repeat (2) @(posedge hclk);
		chk(hd_out, exp_hd(port, 0));
		wr(ddt_pkg::A_IRQ_MASK, 2);
		#1 chk(irq, 0);
		wr(ddt_pkg::A_IRQ_MASK, 3);
		wr(ddt_pkg::A_IRQ_STAT, 1);
		reload_run(ddt_pkg::A_T1_CTRL, ddt_pkg::A_T1_LOAD, 2, 32, 1);
		reload_run(ddt_pkg::A_T2_CTRL, ddt_pkg::A_T2_LOAD, 1, 512, 2);
		stop_test();
	end
endmodule
